// ---- core/jdi_unit.sv ----
`timescale 1ns/1ps
// Function
// - Register 67 bit 1 enables jack detection
// - Jack debounce 32 to 512 ms, bits 4:2
// - Button debounce bits 1:0; bit 1 is also the enable, so 32 ms while enabled
// - Register 45 bits 5:4 show live state
// - Button event sets sticky flag 44 bit 5
// - Insert or removal sets sticky flag 44 bit 4
// - Sticky flags clear only on their read
// - Headset type reported in register 67 bits 6:5
// - Two interrupt outputs, configured by registers 48, 49
// - Any selected event combination triggers each output
// - Registers 52, 53, 55 route interrupts to pins
// - Config bit 0 selects single pulse or train
// - Train stops when registers 42, 44, 45 read
// - Page 1 register 10 bit 6 selects common mode
// - One common-mode setting drives every path
// - Eight-bit registers selected through a page register
module jdi_unit
  import jdi_pkg::*;
#(
  parameter int JACK_DB_CYC = jdi_pkg::JACK_DB_MIN_CYC,
  parameter int BTN_DB_CYC  = jdi_pkg::BTN_DB_MIN_CYC,
  parameter int PULSE_CYC   = jdi_pkg::IRQ_PULSE_CYC,
  parameter int PERIOD_CYC  = jdi_pkg::IRQ_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Register port from the control interface
  input  wire jdi_pkg::jdi_req_type req,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  // Jack sensing
  input  wire logic              jack_raw,
  input  wire logic              btn_raw,
  input  wire logic [1:0]        headset_type,
  // Other event sources, one-cycle pulses
  input  wire jdi_pkg::jdi_src_type src_evt,
  // Pin functions shared with the interrupts
  input  wire logic              gpio_func,
  input  wire logic              dout_func,
  input  wire logic              miso_func,
  output logic                   gpio_out,
  output logic                   dout_out,
  output logic                   miso_out,
  // Interrupt lines and analog controls
  output logic                   irq_out_a,
  output logic                   irq_out_b,
  output logic                   cm_low_sel,
  output logic                   analog_pd
);
  import jdi_pkg::*;

  typedef struct packed {
    logic [7:0]                page;
    logic [1:0][7:0]           irq_cfg;
    logic [2:0][1:0]           pin_sel;
    logic [7:0]                det_ctl;
    logic                      flag_btn;
    logic                      flag_hs;
    jdi_src_type               flag_misc;
    logic [7:0]                ana_pwr;
    logic [7:0]                cm_ctl;
    logic                      jack_prev;
    logic                      btn_prev;
    jdi_irq_st_type [1:0]      irq_st;
    logic [1:0][IRQ_CNT_W-1:0] irq_cnt;
    logic [1:0]                irq;
    logic [7:0]                rd_data;
    logic                      rd_valid;
  } jdi_st_type;

  jdi_st_type  st_ff;
  jdi_st_type  nxt_st;
  logic        det_en;
  logic        jack_st;
  logic        btn_st;
  logic        hs_evt;
  logic        btn_evt;
  logic        flag_read;
  logic        rd44;
  jdi_evt_type evts;
  logic [DB_W-1:0] jack_win;
  logic [DB_W-1:0] btn_win;

  // ==========================================================
  // Helpers
  function automatic logic [DB_W-1:0] db_window(input int base,
                                                input logic [2:0] sh);
    db_window = DB_W'(base) << sh;
  endfunction

  function automatic logic pin_mux(input logic [1:0] sel,
                                   input logic func,
                                   input logic [1:0] irq);
    case (sel)
      PIN_SEL_IRQ_A: pin_mux = irq[0];
      PIN_SEL_IRQ_B: pin_mux = irq[1];
      default:       pin_mux = func;
    endcase
  endfunction

  // ==========================================================
  // Detection
  // Detection also needs analog power; bit set means powered down
  assign det_en = st_ff.det_ctl[DET_EN_BIT] & ~st_ff.ana_pwr[ANA_PD_BIT];

  always_comb begin
    if (st_ff.det_ctl[JACK_DB_LSB +: 3] >= JACK_DB_MAX_CODE) begin
      jack_win = db_window(JACK_DB_CYC, JACK_DB_MAX_CODE);
    end else begin
      jack_win = db_window(JACK_DB_CYC, st_ff.det_ctl[JACK_DB_LSB +: 3]);
    end
    if (st_ff.det_ctl[1:0] >= BTN_DB_MAX_CODE) begin
      btn_win = db_window(BTN_DB_CYC, {1'b0, BTN_DB_MAX_CODE});
    end else begin
      btn_win = db_window(BTN_DB_CYC, {1'b0, st_ff.det_ctl[1:0]});
    end
  end

  jdi_debounce #(.W(DB_W)) u_jack_db (
    .clk    (clk),
    .srst   (srst),
    .en     (det_en),
    .window (jack_win),
    .raw    (jack_raw),
    .stable (jack_st)
  );

  // Button only counts while a headset sits in the jack
  jdi_debounce #(.W(DB_W)) u_btn_db (
    .clk    (clk),
    .srst   (srst),
    .en     (det_en & jack_st),
    .window (btn_win),
    .raw    (btn_raw),
    .stable (btn_st)
  );

  // Edges of filtered levels only, so glitches never reach a flag
  assign hs_evt  = jack_st ^ st_ff.jack_prev;
  assign btn_evt = btn_st & ~st_ff.btn_prev;
  assign evts    = '{hs: hs_evt, btn: btn_evt, src: src_evt};

  assign rd44 = req.rd && (st_ff.page == PAGE0)
                && (req.addr == ADDR_FLAGS_JACK);
  assign flag_read = req.rd && (st_ff.page == PAGE0)
                     && (req.addr == ADDR_FLAGS_MISC
                         || req.addr == ADDR_FLAGS_JACK
                         || req.addr == ADDR_LIVE);

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.jack_prev = jack_st;
    nxt_st.btn_prev  = btn_st;
    nxt_st.rd_valid  = req.rd;

    // Writes; the page register answers on every page
    if (req.wr) begin
      if (req.addr == ADDR_PAGE) begin
        nxt_st.page = req.wdata;
      end else if (st_ff.page == PAGE0) begin
        case (req.addr)
          ADDR_IRQ_A:    nxt_st.irq_cfg[0] = req.wdata;
          ADDR_IRQ_B:    nxt_st.irq_cfg[1] = req.wdata;
          ADDR_GPIO_CTL: nxt_st.pin_sel[0] = req.wdata[1:0];
          ADDR_DOUT_CTL: nxt_st.pin_sel[1] = req.wdata[1:0];
          ADDR_MISO_CTL: nxt_st.pin_sel[2] = req.wdata[1:0];
          ADDR_DET_CTL: begin
            // Type bits belong to the detector, not to software
            nxt_st.det_ctl = {req.wdata[7],
                              st_ff.det_ctl[TYPE_LSB +: 2],
                              req.wdata[4:0]};
          end
          default: ;
        endcase
      end else if (st_ff.page == PAGE1) begin
        case (req.addr)
          ADDR_ANA_PWR: nxt_st.ana_pwr = req.wdata;
          ADDR_CM_CTL:  nxt_st.cm_ctl  = req.wdata;
          default: ;
        endcase
      end
    end

    if (hs_evt && jack_st) begin
      nxt_st.det_ctl[TYPE_LSB +: 2] = headset_type;
    end

    // Sticky flags: the event term comes last so it wins
    if (rd44) begin
      nxt_st.flag_btn = 1'b0;
      nxt_st.flag_hs  = 1'b0;
    end
    if (req.rd && st_ff.page == PAGE0 && req.addr == ADDR_FLAGS_MISC) begin
      nxt_st.flag_misc = '0;
    end
    nxt_st.flag_btn  = nxt_st.flag_btn | btn_evt;
    nxt_st.flag_hs   = nxt_st.flag_hs | hs_evt;
    nxt_st.flag_misc = nxt_st.flag_misc | src_evt;

    // Reads, answered one cycle later from a register
    if (req.rd) begin
      nxt_st.rd_data = RST_REG;
      if (req.addr == ADDR_PAGE) begin
        nxt_st.rd_data = st_ff.page;
      end else if (st_ff.page == PAGE0) begin
        case (req.addr)
          ADDR_FLAGS_MISC: nxt_st.rd_data[MISC_LSB +: 5] = st_ff.flag_misc;
          ADDR_FLAGS_JACK: begin
            nxt_st.rd_data[FLAG_BTN_BIT] = st_ff.flag_btn;
            nxt_st.rd_data[FLAG_HS_BIT]  = st_ff.flag_hs;
          end
          ADDR_LIVE: begin
            nxt_st.rd_data[FLAG_BTN_BIT] = btn_st;
            nxt_st.rd_data[FLAG_HS_BIT]  = jack_st;
          end
          ADDR_IRQ_A:    nxt_st.rd_data = st_ff.irq_cfg[0];
          ADDR_IRQ_B:    nxt_st.rd_data = st_ff.irq_cfg[1];
          ADDR_GPIO_CTL: nxt_st.rd_data[1:0] = st_ff.pin_sel[0];
          ADDR_DOUT_CTL: nxt_st.rd_data[1:0] = st_ff.pin_sel[1];
          ADDR_MISO_CTL: nxt_st.rd_data[1:0] = st_ff.pin_sel[2];
          ADDR_DET_CTL:  nxt_st.rd_data = st_ff.det_ctl;
          default: ;
        endcase
      end else if (st_ff.page == PAGE1) begin
        case (req.addr)
          ADDR_ANA_PWR: nxt_st.rd_data = st_ff.ana_pwr;
          ADDR_CM_CTL:  nxt_st.rd_data = st_ff.cm_ctl;
          default: ;
        endcase
      end
    end

    // Interrupt generators, one per output
    for (int i = 0; i < 2; i++) begin
      case (st_ff.irq_st[i])
        IRQ_IDLE: begin
          nxt_st.irq_cnt[i] = '0;
          nxt_st.irq[i]     = 1'b0;
          if ((st_ff.irq_cfg[i][7:1] & evts) != '0) begin
            nxt_st.irq[i] = 1'b1;
            if (st_ff.irq_cfg[i][IRQ_MODE_BIT]) begin
              nxt_st.irq_st[i] = IRQ_TRAIN;
            end else begin
              nxt_st.irq_st[i] = IRQ_ONE;
            end
          end
        end
        IRQ_ONE: begin
          // Further events during the pulse merge into it
          nxt_st.irq_cnt[i] = st_ff.irq_cnt[i] + IRQ_CNT_W'(1);
          if (st_ff.irq_cnt[i] >= IRQ_CNT_W'(PULSE_CYC - 1)) begin
            nxt_st.irq_st[i] = IRQ_IDLE;
            nxt_st.irq[i]    = 1'b0;
          end
        end
        IRQ_TRAIN: begin
          if (flag_read) begin
            nxt_st.irq_st[i] = IRQ_IDLE;
            nxt_st.irq[i]    = 1'b0;
            nxt_st.irq_cnt[i] = '0;
          end else begin
            if (st_ff.irq_cnt[i] >= IRQ_CNT_W'(PERIOD_CYC - 1)) begin
              nxt_st.irq_cnt[i] = '0;
            end else begin
              nxt_st.irq_cnt[i] = st_ff.irq_cnt[i] + IRQ_CNT_W'(1);
            end
            nxt_st.irq[i] = nxt_st.irq_cnt[i] < IRQ_CNT_W'(PULSE_CYC);
          end
        end
        default: begin
          nxt_st.irq_st[i] = IRQ_IDLE;
          nxt_st.irq[i]    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign rd_data    = st_ff.rd_data;
  assign rd_valid   = st_ff.rd_valid;
  assign irq_out_a  = st_ff.irq[0];
  assign irq_out_b  = st_ff.irq[1];
  assign cm_low_sel = st_ff.cm_ctl[CM_BIT];
  assign analog_pd  = st_ff.ana_pwr[ANA_PD_BIT];
  assign gpio_out   = pin_mux(st_ff.pin_sel[0], gpio_func, st_ff.irq);
  assign dout_out   = pin_mux(st_ff.pin_sel[1], dout_func, st_ff.irq);
  assign miso_out   = pin_mux(st_ff.pin_sel[2], miso_func, st_ff.irq);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_det_off;
    !det_en |=> !jack_st;
  endproperty
  a_det_off: assert property (p_det_off)
    else $error("jack state set while detection off");

  property p_live;
    req.rd && st_ff.page == PAGE0 && req.addr == ADDR_LIVE
      |=> rd_valid && rd_data[5:4] == $past({btn_st, jack_st});
  endproperty
  a_live: assert property (p_live)
    else $error("live status read mismatch");

  property p_btn_set;
    btn_evt |=> st_ff.flag_btn;
  endproperty
  a_btn_set: assert property (p_btn_set)
    else $error("button flag not set");

  property p_hs_set;
    hs_evt && rd44 |=> st_ff.flag_hs;
  endproperty
  a_hs_set: assert property (p_hs_set)
    else $error("headset event lost on clearing read");

  property p_flag_hold;
    st_ff.flag_hs && !rd44 |=> st_ff.flag_hs;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("headset flag dropped without read");

  property p_flag_clr;
    rd44 && !hs_evt && !btn_evt |=> !st_ff.flag_hs && !st_ff.flag_btn;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("sticky flags survived their read");

  property p_type;
    hs_evt && jack_st |=> st_ff.det_ctl[6:5] == $past(headset_type);
  endproperty
  a_type: assert property (p_type)
    else $error("headset type not captured");

  property p_single;
    st_ff.irq_st[0] == IRQ_IDLE && !st_ff.irq_cfg[0][IRQ_MODE_BIT]
      && (st_ff.irq_cfg[0][7:1] & evts) != '0 |=> irq_out_a [*2];
  endproperty
  a_single: assert property (p_single)
    else $error("single pulse not raised");

  property p_quiet;
    st_ff.irq_st[1] == IRQ_IDLE && (st_ff.irq_cfg[1][7:1] & evts) == '0
      |=> !irq_out_b;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("interrupt b raised without selected event");

  property p_train_stop;
    st_ff.irq_st[0] == IRQ_TRAIN && flag_read |=> !irq_out_a;
  endproperty
  a_train_stop: assert property (p_train_stop)
    else $error("pulse train did not stop on flag read");

  property p_cm;
    req.wr && st_ff.page == PAGE1 && req.addr == ADDR_CM_CTL
      |=> cm_low_sel == $past(req.wdata[6]);
  endproperty
  a_cm: assert property (p_cm)
    else $error("common mode select not written");

  property p_route;
    st_ff.pin_sel[0] == PIN_SEL_IRQ_B |-> gpio_out == irq_out_b;
  endproperty
  a_route: assert property (p_route)
    else $error("gpio not carrying interrupt b");

  property p_glitch;
    // Switching detection off drops the state on purpose, so skip that case
    $past(det_en) && jack_st != $past(jack_st)
      |-> $past(jack_raw) == jack_st;
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("jack state moved against raw level");

  c_insert: cover property (hs_evt && jack_st);
  c_train:  cover property (st_ff.irq_st[0] == IRQ_TRAIN && flag_read);
  c_race:   cover property (btn_evt && rd44);
endmodule // jdi_unit

// ---- core/jdi_pkg.sv ----
package jdi_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_KHZ        = 50000;
  localparam int JACK_DB_MIN_MS = 32;
  localparam int BTN_DB_MIN_MS  = 8;
  localparam int IRQ_PULSE_US   = 2000;
  localparam int IRQ_PERIOD_US  = 4000;
  localparam int JACK_DB_MIN_CYC = JACK_DB_MIN_MS * CLK_KHZ;
  localparam int BTN_DB_MIN_CYC  = BTN_DB_MIN_MS * CLK_KHZ;
  localparam int IRQ_PULSE_CYC   = IRQ_PULSE_US * CLK_KHZ / 1000;
  localparam int IRQ_PERIOD_CYC  = IRQ_PERIOD_US * CLK_KHZ / 1000;
  localparam int DB_W      = 26;
  localparam int IRQ_CNT_W = 20;
  // Largest debounce codes: 512 ms is 32 ms << 4, 32 ms is 8 ms << 2
  localparam logic [2:0] JACK_DB_MAX_CODE = 3'h4;
  localparam logic [1:0] BTN_DB_MAX_CODE  = 2'h2;
  // ==========================================================
  // Register map
  localparam logic [7:0] PAGE0 = 8'h00;
  localparam logic [7:0] PAGE1 = 8'h01;
  localparam logic [6:0] ADDR_PAGE       = 7'h00;
  localparam logic [6:0] ADDR_FLAGS_MISC = 7'h2a;
  localparam logic [6:0] ADDR_FLAGS_JACK = 7'h2c;
  localparam logic [6:0] ADDR_LIVE       = 7'h2d;
  localparam logic [6:0] ADDR_IRQ_A      = 7'h30;
  localparam logic [6:0] ADDR_IRQ_B      = 7'h31;
  localparam logic [6:0] ADDR_GPIO_CTL   = 7'h34;
  localparam logic [6:0] ADDR_DOUT_CTL   = 7'h35;
  localparam logic [6:0] ADDR_MISO_CTL   = 7'h37;
  localparam logic [6:0] ADDR_DET_CTL    = 7'h43;
  localparam logic [6:0] ADDR_ANA_PWR    = 7'h02;
  localparam logic [6:0] ADDR_CM_CTL     = 7'h0a;
  localparam logic [7:0] RST_REG         = 8'h00;
  // ==========================================================
  // Field positions
  localparam int DET_EN_BIT   = 1;
  localparam int JACK_DB_LSB  = 2;
  localparam int TYPE_LSB     = 5;
  localparam int FLAG_BTN_BIT = 5;
  localparam int FLAG_HS_BIT  = 4;
  localparam int IRQ_MODE_BIT = 0;
  localparam int ANA_PD_BIT   = 3;
  localparam int CM_BIT       = 6;
  localparam int MISC_LSB     = 3;
  localparam logic [1:0] PIN_SEL_FUNC  = 2'h0;
  localparam logic [1:0] PIN_SEL_IRQ_A = 2'h1;
  localparam logic [1:0] PIN_SEL_IRQ_B = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    IRQ_IDLE  = 2'b00,
    IRQ_ONE   = 2'b01,
    IRQ_TRAIN = 2'b10
  } jdi_irq_st_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } jdi_req_type;

  // Order matches bits 7:3 of the misc flag register
  typedef struct packed {
    logic dynamic_range_compressor;
    logic auto_gain_loop;
    logic ovc;
    logic ovf;
    logic dc;
  } jdi_src_type;

  // Order matches bits 7:1 of an interrupt config register
  typedef struct packed {
    logic        hs;
    logic        btn;
    jdi_src_type src;
  } jdi_evt_type;
endpackage

// ---- core/jdi_debounce.sv ----
`timescale 1ns/1ps
module jdi_debounce #(
  parameter int W = jdi_pkg::DB_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Control
  input  wire logic         en,
  input  wire logic [W-1:0] window,
  // Detector
  input  wire logic         raw,
  output logic              stable
);
  import jdi_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         stable;
  } jdi_db_st_type;

  jdi_db_st_type st_ff;
  jdi_db_st_type nxt_st;

  // ==========================================================
  // Filter: raw must hold a changed level for a full window
  always_comb begin
    nxt_st = st_ff;
    if (!en) begin
      nxt_st.cnt    = '0;
      nxt_st.stable = 1'b0;
    end else if (raw == st_ff.stable) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt >= window - W'(1)) begin
      nxt_st.cnt    = '0;
      nxt_st.stable = raw;
    end else begin
      nxt_st.cnt = st_ff.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign stable = st_ff.stable;
endmodule // jdi_debounce

// ---- testbench/jdi_host_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Host processor side of the register port
module jdi_host_model
  import jdi_pkg::*;
(
  // Clock
  input  wire logic           clk,
  // Register port
  output jdi_pkg::jdi_req_type req,
  input  wire logic [7:0]     rd_data,
  input  wire logic           rd_valid
);
  import jdi_pkg::*;

  initial req = '0;

  // One request a call, held for exactly one rising edge
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk);
    req = '0;
  endtask

  // No answer within three cycles leaves the result unknown
  task automatic reg_rd(input logic [6:0] a, output logic [7:0] v);
    int n;
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    v = 8'hxx;
    for (n = 0; n < 3; n++) begin
      if (rd_valid === 1'b1) begin
        v = rd_data;
        break;
      end
      @(negedge clk);
    end
  endtask

  // Analog core must be on before detection is trusted
  task automatic power_up();
    reg_wr(ADDR_PAGE, PAGE1);
    reg_wr(ADDR_ANA_PWR, 8'h00);
    reg_wr(ADDR_PAGE, PAGE0);
  endtask

  // Cause lookup; these reads also stop a pulse train
  task automatic read_cause();
    logic [7:0] v;
    reg_rd(ADDR_FLAGS_MISC, v);
    reg_rd(ADDR_FLAGS_JACK, v);
    reg_rd(ADDR_LIVE, v);
  endtask
endmodule // jdi_host_model

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
// ==========================================================
// Testbench top
module tb;
  import jdi_pkg::*;
  localparam int PUL = 3;
  localparam int PER = 8;
  logic        clk, srst, jack_raw, btn_raw;
  logic        gpio_func, dout_func, miso_func;
  logic [1:0]  headset_type;
  jdi_src_type src_evt;
  jdi_req_type req;
  logic [7:0]  rd_data, d;
  logic        rd_valid, gpio_out, dout_out, miso_out;
  logic        irq_out_a, irq_out_b, cm_low_sel, analog_pd, prev;
  int          errors, n_compared, cyc, k, i;

  jdi_unit #(.JACK_DB_CYC(8), .BTN_DB_CYC(4), .PULSE_CYC(PUL),
    .PERIOD_CYC(PER)) u_dut (.clk(clk), .srst(srst), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .jack_raw(jack_raw),
    .btn_raw(btn_raw), .headset_type(headset_type), .src_evt(src_evt),
    .gpio_func(gpio_func), .dout_func(dout_func), .miso_func(miso_func),
    .gpio_out(gpio_out), .dout_out(dout_out), .miso_out(miso_out),
    .irq_out_a(irq_out_a), .irq_out_b(irq_out_b),
    .cm_low_sel(cm_low_sel), .analog_pd(analog_pd));

  jdi_host_model u_host (.clk(clk), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid));

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    u_host.reg_rd(a, d);
    check(d, exp);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic logic pick(input bit b);
    return b ? irq_out_b : irq_out_a;
  endfunction

  // Waits for a pulse, then counts its high cycles
  task automatic irq_len(input bit b, output int n);
    int t;
    n = 0;
    for (t = 0; t < 60 && pick(b) !== 1'b1; t++) @(negedge clk);
    while (pick(b) === 1'b1 && n < 60) begin
      n++;
      @(negedge clk);
    end
  endtask

  task automatic print_verdict();
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    srst = 1'b1;
    jack_raw = 1'b0;
    btn_raw = 1'b0;
    headset_type = 2'h2;
    src_evt = '0;
    gpio_func = 1'b1;
    dout_func = 1'b1;
    miso_func = 1'b1;
    errors = 0;
    n_compared = 0;
    cyc = 0;
    wait_cyc(2);
    srst = 1'b0;
    rd_chk(ADDR_FLAGS_JACK, 8'h00);
    rd_chk(ADDR_LIVE, 8'h00);
    rd_chk(ADDR_IRQ_B, 8'h00);
    rd_chk(7'h7f, 8'h00);
    u_host.reg_wr(ADDR_IRQ_A, 8'ha5);
    u_host.reg_wr(ADDR_IRQ_B, 8'h5a);
    rd_chk(ADDR_IRQ_A, 8'ha5);
    rd_chk(ADDR_IRQ_B, 8'h5a);
    u_host.reg_wr(ADDR_IRQ_A, 8'h00);
    u_host.reg_wr(ADDR_IRQ_B, 8'h00);
    u_host.reg_wr(ADDR_PAGE, PAGE1);
    u_host.reg_wr(ADDR_CM_CTL, 8'h40);
    u_host.reg_wr(ADDR_ANA_PWR, 8'h08);
    rd_chk(ADDR_CM_CTL, 8'h40);
    check({7'h0, cm_low_sel}, 8'h01);
    check({7'h0, analog_pd}, 8'h01);
    u_host.power_up();
    check({7'h0, analog_pd}, 8'h00);
    rd_chk(ADDR_IRQ_A, 8'h00);
    $display("test registers done");
    // Detection switched off: insertion must stay unseen
    jack_raw = 1'b1;
    wait_cyc(40);
    rd_chk(ADDR_LIVE, 8'h00);
    rd_chk(ADDR_FLAGS_JACK, 8'h00);
    jack_raw = 1'b0;
    u_host.reg_wr(ADDR_DET_CTL, 8'h02);
    wait_cyc(40);
    jack_raw = 1'b1;
    wait_cyc(3);
    jack_raw = 1'b0;
    wait_cyc(30);
    rd_chk(ADDR_FLAGS_JACK, 8'h00);
    // Window code 1 doubles the jack window to 16 cycles
    u_host.reg_wr(ADDR_DET_CTL, 8'h06);
    jack_raw = 1'b1;
    wait_cyc(10);
    rd_chk(ADDR_LIVE, 8'h00);
    wait_cyc(30);
    rd_chk(ADDR_LIVE, 8'h10);
    rd_chk(ADDR_FLAGS_JACK, 8'h10);
    rd_chk(ADDR_FLAGS_JACK, 8'h00);
    u_host.reg_wr(ADDR_DET_CTL, 8'h66);
    rd_chk(ADDR_DET_CTL, 8'h46);
    btn_raw = 1'b1;
    wait_cyc(10);
    rd_chk(ADDR_LIVE, 8'h10);
    wait_cyc(30);
    rd_chk(ADDR_LIVE, 8'h30);
    rd_chk(ADDR_FLAGS_JACK, 8'h20);
    btn_raw = 1'b0;
    wait_cyc(40);
    rd_chk(ADDR_FLAGS_JACK, 8'h00);
    $display("test detection done");
    // Single pulse on removal
    u_host.reg_wr(ADDR_IRQ_A, 8'h80);
    jack_raw = 1'b0;
    irq_len(1'b0, k);
    check(8'(k), 8'(PUL));
    check({7'h0, irq_out_b}, 8'h00);
    wait_cyc(20);
    check({7'h0, irq_out_a}, 8'h00);
    rd_chk(ADDR_FLAGS_JACK, 8'h10);
    // Pulse train on button press, stopped by the cause reads
    u_host.reg_wr(ADDR_IRQ_B, 8'h41);
    jack_raw = 1'b1;
    wait_cyc(40);
    rd_chk(ADDR_FLAGS_JACK, 8'h10);
    btn_raw = 1'b1;
    irq_len(1'b1, k);
    check(8'(k), 8'(PUL));
    check({7'h0, irq_out_a}, 8'h00);
    k = 0;
    prev = irq_out_b;
    repeat (PER) begin
      @(negedge clk);
      if (irq_out_b === 1'b1 && prev !== 1'b1)
        k++;
      prev = irq_out_b;
    end
    check(8'(k), 8'h01);
    u_host.read_cause();
    wait_cyc(2);
    k = 0;
    repeat (2 * PER) begin
      @(negedge clk);
      if (irq_out_b !== 1'b0)
        k++;
    end
    check(8'(k), 8'h00);
    btn_raw = 1'b0;
    u_host.reg_wr(ADDR_IRQ_B, 8'h00);
    $display("test interrupt modes done");
    // Each other source alone, routed to the general pin
    u_host.reg_wr(ADDR_GPIO_CTL, 8'h01);
    u_host.reg_wr(ADDR_DOUT_CTL, 8'h02);
    u_host.reg_wr(ADDR_MISO_CTL, 8'h03);
    check({7'h0, gpio_out}, 8'h00);
    check({7'h0, dout_out}, 8'h00);
    check({7'h0, miso_out}, 8'h01);
    for (i = 0; i < 5; i++) begin
      u_host.reg_wr(ADDR_IRQ_A, 8'(1 << (i + 1)));
      @(negedge clk);
      src_evt = jdi_src_type'(5'(1 << i));
      @(negedge clk);
      src_evt = '0;
      check({7'h0, gpio_out}, 8'h01);
      irq_len(1'b0, k);
      check(8'(k), 8'(PUL));
      rd_chk(ADDR_FLAGS_MISC, 8'(1 << (i + 3)));
    end
    $display("test event sources done");
    print_verdict();
  end
endmodule // tb
